// >>> hdl/driver_protection_supervisor.sv
// protection supervisor: limit measurement, faults, restart, latch-off
`timescale 1ns/1ps
`default_nettype none
module driver_protection_supervisor #(
  parameter int RESTART_CYC = driver_protection_pkg::RESTART_CYC,
  parameter int SOFTSTART_CYC = driver_protection_pkg::SOFTSTART_CYC,
  parameter int SLOW_TRIP_CYC = driver_protection_pkg::SLOW_TRIP_CYC,
  parameter int SETTLE_CYC = driver_protection_pkg::SETTLE_CYC
) (
  // clock and reset, reset stands for a supply cycle
  input wire logic clk,
  input wire logic rst,
  // analog comparator levels
  input wire driver_protection_pkg::sense_s sense,
  // sampled program pin voltage
  input wire logic [9:0] pinCode,
  // disable/fault pin, open drain
  input wire logic disablePinIn,
  output logic disablePinOut,
  output logic disablePinOe,
  // measurement source
  output logic sourceOn,
  // power stage and regulator control
  output logic switchEnable,
  output logic regulatorEnable,
  output logic regHighLimit,
  // current limits
  output logic [2:0] limitLevel,
  output logic [4:0] fastTripSixths,
  output logic fastTripSoftStart,
  output logic slowTripEnable,
  // oscillator selection
  output logic freqForceMax,
  output logic syncSelect,
  // status
  output driver_protection_pkg::fault_flags_s faults,
  output logic inFault,
  output logic latchedOff
);
  driver_protection_pkg::state_e state_q; // supervisor state
  driver_protection_pkg::state_e state_d; // next state
  driver_protection_pkg::fault_flags_s flags_q; // fault causes
  driver_protection_pkg::fault_flags_s flags_d; // next causes
  logic [9:0] sampleOn_q; // pin code with source on
  logic [9:0] diff; // on minus off, clamped at zero
  logic [2:0] level_q; // selected limit in sixths
  logic [2:0] level_d; // decoded band
  logic [24:0] slowCnt_q; // slow trip up-down timer
  logic [24:0] slowTrip; // slow timer trip count
  logic slowHit; // slow timer at trip
  logic vregSeenGood_q; // regulator reached good once
  logic stateChange; // clears the phase timers
  logic settleDone; // pin has settled
  logic ovHeld; // overvoltage held past blanking
  logic restartDone; // restart delay elapsed
  logic softDone; // soft-start over
  logic latchCause; // regulator fault needing latch-off
  logic runFault; // recoverable fault now
  logic recoverOk; // every active cause recovered
  logic operating; // soft-start or run

  assign stateChange = (state_d != state_q);
  assign operating = (state_q == driver_protection_pkg::ST_SOFT)
                  || (state_q == driver_protection_pkg::ST_RUN);

  // pin settling before each sample; assumes a short pin time constant
  hold_timer #(
    .N(SETTLE_CYC)
  ) settleTimer (
    .clk(clk),
    .rst(rst),
    .en((state_q == driver_protection_pkg::ST_MEAS_ON)
        || (state_q == driver_protection_pkg::ST_MEAS_OFF)),
    .clr(stateChange),
    .done(settleDone)
  );

  // the trip comparator level is fixed, only its duration is judged
  hold_timer #(
    .N(driver_protection_pkg::OV_BLANK_CYC)
  ) ovBlankTimer (
    .clk(clk),
    .rst(rst),
    .en(sense.vccAboveTrip),
    .clr(1'b0),
    .done(ovHeld)
  );

  // restart delay runs through the whole fault stay
  hold_timer #(
    .N(RESTART_CYC)
  ) restartTimer (
    .clk(clk),
    .rst(rst),
    .en(state_q == driver_protection_pkg::ST_FAULT),
    .clr(stateChange),
    .done(restartDone)
  );

  // soft-start period
  hold_timer #(
    .N(SOFTSTART_CYC)
  ) softTimer (
    .clk(clk),
    .rst(rst),
    .en(state_q == driver_protection_pkg::ST_SOFT),
    .clr(stateChange),
    .done(softDone)
  );

  // difference of the two samples; negative reads as zero
  always_comb begin
    if (pinCode > sampleOn_q) begin
      diff = '0;
    end else begin
      diff = sampleOn_q - pinCode;
    end
  end

  // band decode: larger resistance gives a smaller limit
  always_comb begin
    if (diff >= driver_protection_pkg::B12_CODE) begin
      level_d = driver_protection_pkg::LVL_MIN;
    end else if (diff >= driver_protection_pkg::B23_CODE) begin
      level_d = 3'h2;
    end else if (diff >= driver_protection_pkg::B34_CODE) begin
      level_d = 3'h3;
    end else if (diff >= driver_protection_pkg::B45_CODE) begin
      level_d = 3'h4;
    end else if (diff >= driver_protection_pkg::B56_CODE) begin
      level_d = 3'h5;
    end else begin
      level_d = driver_protection_pkg::LVL_MAX;
    end
  end

  // sample with source on at end of its settle window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampleOn_q <= '0;
    end else if (state_q == driver_protection_pkg::ST_MEAS_ON && settleDone) begin
      sampleOn_q <= pinCode;
    end
  end

  // limit level latched from the source-off sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_q <= driver_protection_pkg::LVL_MAX;
    end else if (state_q == driver_protection_pkg::ST_MEAS_OFF && settleDone) begin
      level_q <= level_d;
    end
  end

  // slow trip timer: counts only after soft-start, steps keep 2.1/180 ms
  assign slowTrip = 25'(SLOW_TRIP_CYC) * driver_protection_pkg::SLOW_UP_STEP;
  assign slowHit = (slowCnt_q >= slowTrip);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slowCnt_q <= '0;
    end else if (state_q != driver_protection_pkg::ST_RUN) begin
      slowCnt_q <= '0;
    end else if (sense.slowOcAbove) begin
      if (!slowHit) begin
        slowCnt_q <= slowCnt_q + driver_protection_pkg::SLOW_UP_STEP;
      end
    end else if (slowCnt_q >= driver_protection_pkg::SLOW_DN_STEP) begin
      slowCnt_q <= slowCnt_q - driver_protection_pkg::SLOW_DN_STEP;
    end else begin
      slowCnt_q <= '0;
    end
  end

  // remembers the first good regulator level since reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vregSeenGood_q <= 1'b0;
    end else if (sense.vregGood) begin
      vregSeenGood_q <= 1'b1;
    end
  end

  // regulator faults: open at any time, low only in operation
  assign latchCause = sense.vregOpen
                   || (operating && sense.vregLow);

  // recoverable causes seen right now
  always_comb begin
    flags_d = flags_q;
    flags_d.overVolt = ovHeld;
    flags_d.thermal = sense.tempOverTrip;
    flags_d.progOpen = sense.progPinOpen;
    flags_d.progShort = sense.progPinShort;
    flags_d.freqShort = sense.freqPinShort;
    flags_d.slowOc = slowHit;
    flags_d.fastOc = operating && sense.fastOcAbove;
  end
  assign runFault = |flags_d;

  // a cause is released only once its own recovery holds
  always_comb begin
    recoverOk = 1'b1;
    if (flags_q.overVolt && !sense.vccBelowRecover) begin
      recoverOk = 1'b0;
    end
    if (flags_q.thermal && !sense.tempBelowRecover) begin
      recoverOk = 1'b0;
    end
    if ((flags_q.progOpen && sense.progPinOpen)
        || (flags_q.progShort && sense.progPinShort)
        || (flags_q.freqShort && sense.freqPinShort)) begin
      recoverOk = 1'b0;
    end
  end

  // fault causes: gathered on entry and while in fault, cleared on restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else if (state_q == driver_protection_pkg::ST_FAULT) begin
      if (state_d == driver_protection_pkg::ST_SOFT) begin
        flags_q <= '0;
      end else begin
        // new causes other than the two overcurrent ones are added during the stay, never lost
        flags_q <= flags_q | (flags_d & {2'b00, 5'h1f});
      end
    end else if (state_d == driver_protection_pkg::ST_FAULT) begin
      flags_q <= flags_d;
    end
  end

  // next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      driver_protection_pkg::ST_WAIT: begin
        // measurement starts once the regulator has settled
        if (sense.vregGood) begin
          state_d = driver_protection_pkg::ST_MEAS_ON;
        end
      end
      driver_protection_pkg::ST_MEAS_ON: begin
        if (settleDone) begin
          state_d = driver_protection_pkg::ST_MEAS_OFF;
        end
      end
      driver_protection_pkg::ST_MEAS_OFF: begin
        if (settleDone) begin
          state_d = driver_protection_pkg::ST_CHECK;
        end
      end
      driver_protection_pkg::ST_CHECK: begin
        // pin faults are judged after the limit check
        if (runFault) begin
          state_d = driver_protection_pkg::ST_FAULT;
        end else begin
          state_d = driver_protection_pkg::ST_SOFT;
        end
      end
      driver_protection_pkg::ST_SOFT: begin
        if (runFault) begin
          state_d = driver_protection_pkg::ST_FAULT;
        end else if (softDone) begin
          state_d = driver_protection_pkg::ST_RUN;
        end
      end
      driver_protection_pkg::ST_RUN: begin
        if (runFault) begin
          state_d = driver_protection_pkg::ST_FAULT;
        end
      end
      driver_protection_pkg::ST_FAULT: begin
        // delay and every recovery together, then soft-start again
        if (restartDone && recoverOk) begin
          state_d = driver_protection_pkg::ST_SOFT;
        end
      end
      driver_protection_pkg::ST_LATCH: begin
        // only a supply cycle leaves this state
        state_d = driver_protection_pkg::ST_LATCH;
      end
      default: begin
        state_d = driver_protection_pkg::ST_LATCH;
      end
    endcase
    // latch-off overrides every other transition
    if (latchCause) begin
      state_d = driver_protection_pkg::ST_LATCH;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= driver_protection_pkg::ST_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // source is driven only in the first measurement phase
  assign sourceOn = (state_q == driver_protection_pkg::ST_MEAS_ON);

  // disable pin sink: start-up until checks pass, and every recoverable fault, not latch-off
  assign disablePinOut = 1'b0;
  assign disablePinOe = (state_q == driver_protection_pkg::ST_FAULT)
                     || (state_q == driver_protection_pkg::ST_WAIT)
                     || (state_q == driver_protection_pkg::ST_MEAS_ON)
                     || (state_q == driver_protection_pkg::ST_MEAS_OFF)
                     || (state_q == driver_protection_pkg::ST_CHECK);

  // switching only in operation and with the pin high
  assign switchEnable = operating && disablePinIn;

  // regulator off for good after a latch cause
  assign regulatorEnable = (state_q != driver_protection_pkg::ST_LATCH);

  // 40 mA between 1 V and first good level, 15 mA otherwise
  assign regHighLimit = regulatorEnable && sense.vregAbove1V
                     && !vregSeenGood_q;

  // limit outputs; slow trip off and fast trip at 5 A in soft-start
  assign limitLevel = level_q;
  assign slowTripEnable = (state_q == driver_protection_pkg::ST_RUN);
  assign fastTripSoftStart = (state_q != driver_protection_pkg::ST_RUN);
  assign fastTripSixths = FAST5(level_q);

  // five times the level in sixths
  function automatic logic [4:0] FAST5(input logic [2:0] lvl);
    FAST5 = 5'(driver_protection_pkg::FAST_MULT * {2'b00, lvl});
  endfunction : FAST5

  // oscillator: open frequency pin forces 1.2 MHz, short faults above
  assign freqForceMax = sense.freqPinOpen;

  // a missing sync clock only falls back to the set frequency
  assign syncSelect = (state_q == driver_protection_pkg::ST_RUN)
                   && sense.syncValid;

  // status
  assign faults = flags_q;
  assign inFault = (state_q == driver_protection_pkg::ST_FAULT);
  assign latchedOff = (state_q == driver_protection_pkg::ST_LATCH);
endmodule : driver_protection_supervisor
`default_nettype wire

// >>> hdl/driver_protection_pkg.sv
// shared constants and types of the driver protection supervisor
package driver_protection_pkg;
  // clock rate
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // overvoltage blanking, a least time, rounded up
  localparam int OV_BLANK_NS = 1300;
  localparam int OV_BLANK_CYC = (OV_BLANK_NS * CLK_MHZ + 999) / 1000;
  // restart delay after a recoverable fault
  localparam int RESTART_MS = 100;
  localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
  // fixed soft-start period
  localparam int SOFTSTART_US = 1500;
  localparam int SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ;
  // slow trip: up from zero in 2.1 ms, down from trip in 180 ms
  localparam int SLOW_UP_US = 2100;
  localparam int SLOW_TRIP_CYC = SLOW_UP_US * CLK_MHZ;
  localparam int SLOW_DOWN_US = 180000;
  // step ratio 600:7 equals 180 ms : 2.1 ms
  localparam logic [24:0] SLOW_UP_STEP = 25'h0000258;
  localparam logic [24:0] SLOW_DN_STEP = 25'h0000007;
  // pin settling before each sample, five 20 us time constants
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  // measurement source and pin sample scaling
  localparam int SRC_UA = 50;
  localparam int PIN_LSB_UV = 5000;
  // band boundaries in ohms, midway between printed bands
  localparam int B12_OHM = 19625;
  localparam int B23_OHM = 14250;
  localparam int B34_OHM = 9975;
  localparam int B45_OHM = 6525;
  localparam int B56_OHM = 3725;
  localparam logic [9:0] B12_CODE = 10'(B12_OHM * SRC_UA / PIN_LSB_UV);
  localparam logic [9:0] B23_CODE = 10'(B23_OHM * SRC_UA / PIN_LSB_UV);
  localparam logic [9:0] B34_CODE = 10'(B34_OHM * SRC_UA / PIN_LSB_UV);
  localparam logic [9:0] B45_CODE = 10'(B45_OHM * SRC_UA / PIN_LSB_UV);
  localparam logic [9:0] B56_CODE = 10'(B56_OHM * SRC_UA / PIN_LSB_UV);
  // current-limit levels in sixths of the maximum
  localparam logic [2:0] LVL_MIN = 3'h1;
  localparam logic [2:0] LVL_MAX = 3'h6;
  localparam logic [4:0] FAST_MULT = 5'h05;
  // supervisor states, one-hot
  typedef enum logic [7:0] {
    ST_WAIT = 8'h01,
    ST_MEAS_ON = 8'h02,
    ST_MEAS_OFF = 8'h04,
    ST_CHECK = 8'h08,
    ST_SOFT = 8'h10,
    ST_RUN = 8'h20,
    ST_FAULT = 8'h40,
    ST_LATCH = 8'h80
  } state_e;
  // comparator levels from the analog side
  typedef struct packed {
    logic vccAboveTrip;
    logic vccBelowRecover;
    logic tempOverTrip;
    logic tempBelowRecover;
    logic vregAbove1V;
    logic vregGood;
    logic vregLow;
    logic vregOpen;
    logic progPinOpen;
    logic progPinShort;
    logic freqPinOpen;
    logic freqPinShort;
    logic syncValid;
    logic slowOcAbove;
    logic fastOcAbove;
  } sense_s;
  // recorded causes of the active fault
  typedef struct packed {
    logic slowOc;
    logic fastOc;
    logic overVolt;
    logic thermal;
    logic progOpen;
    logic progShort;
    logic freqShort;
  } fault_flags_s;
endpackage : driver_protection_pkg

// >>> hdl/hold_timer.sv
// saturating persistence timer with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
  parameter int N = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic en,
  input wire logic clr,
  // status
  output logic done
);
  localparam int W = $clog2(N + 1);
  localparam logic [W-1:0] LAST = W'(N);
  logic [W-1:0] cnt_q; // cycles counted so far

  // counts while enabled, drops to zero when disabled or cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (clr || !en) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = (cnt_q == LAST);
endmodule : hold_timer
`default_nettype wire

// >>> testbench/prog_pin_model.sv
// far side model: resistor divider on the program pin and the disable pin pull-up
`timescale 1ns/1ps
`default_nettype none
module prog_pin_model (
  // from the supervisor
  input wire logic sourceOn,
  input wire logic disablePinOe,
  input wire logic disablePinOut,
  // divider setup and outside pull-down
  input wire logic [9:0] baseCode,
  input wire logic [9:0] deltaCode,
  input wire logic extDisable,
  // to the supervisor
  output logic [9:0] pinCode,
  output logic disablePinIn
);
  // small time constant, no pin capacitor, so the step settles at once
  assign pinCode = sourceOn ? baseCode + deltaCode : baseCode;
  // open drain with pull-up; an outside pull-down wins over it
  assign disablePinIn = (disablePinOe ? disablePinOut : 1'b1) & !extDisable;
  // regulator load kept light: this model never pulls the regulator low
endmodule : prog_pin_model
`default_nettype wire

// >>> testbench/driver_protection_supervisor_properties.sv
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module driver_protection_supervisor_checker #(
  parameter int RESTART_CYC = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire driver_protection_pkg::sense_s sense,
  input wire logic [9:0] pinCode,
  input wire logic disablePinIn,
  // outputs
  input wire logic disablePinOut,
  input wire logic disablePinOe,
  input wire logic sourceOn,
  input wire logic switchEnable,
  input wire logic regulatorEnable,
  input wire logic regHighLimit,
  input wire logic [2:0] limitLevel,
  input wire logic [4:0] fastTripSixths,
  input wire logic fastTripSoftStart,
  input wire logic slowTripEnable,
  input wire logic freqForceMax,
  input wire logic syncSelect,
  input wire driver_protection_pkg::fault_flags_s faults,
  input wire logic inFault,
  input wire logic latchedOff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] ovRun_q; // consecutive over-trip samples, saturating
  logic ovSeen_q; // a full blanking span was seen since the last run
  int faultLen_q; // cycles spent in fault so far
  // count the over-trip run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovRun_q <= 4'h0;
    end else if (!sense.vccAboveTrip) begin
      ovRun_q <= 4'h0;
    end else if (ovRun_q != 4'hd) begin
      ovRun_q <= ovRun_q + 4'h1;
    end
  end
  // remember a complete span until running again, as the flag may act late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovSeen_q <= 1'b0;
    end else if (ovRun_q == 4'hd) begin
      ovSeen_q <= 1'b1;
    end else if (slowTripEnable) begin
      ovSeen_q <= 1'b0;
    end
  end
  // fault length, restarts at zero outside fault
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultLen_q <= 0;
    end else if (inFault) begin
      faultLen_q <= faultLen_q + 1;
    end else begin
      faultLen_q <= 0;
    end
  end
  AST_SRC_OFF_SWITCH: assert property (
    sourceOn |-> !switchEnable && !slowTripEnable) else $error("source on while switching");
  AST_FAULT_SINK: assert property (
    inFault |-> disablePinOe && !switchEnable) else $error("fault without sink or stop");
  AST_DIS_INHIBIT: assert property (
    !disablePinIn |-> !switchEnable) else $error("switching with pin low");
  AST_FAST_LEVEL: assert property (
    fastTripSixths == 5'(limitLevel) * 5'h05) else $error("fast trip not five times");
  AST_FAST_SOFT: assert property (
    (switchEnable || slowTripEnable) |-> fastTripSoftStart != slowTripEnable)
    else $error("fast level or slow timer wrong for phase");
  AST_LEVEL_RANGE: assert property (
    limitLevel >= 3'h1 && limitLevel <= 3'h6) else $error("limit level outside six bands");
  AST_OV_BLANK: assert property (
    $rose(faults.overVolt) |-> ovSeen_q) else $error("overvoltage before blanking");
  AST_RESTART_DELAY: assert property (
    $fell(inFault) && !latchedOff |-> faultLen_q >= RESTART_CYC)
    else $error("restart before delay");
  AST_LATCH_HOLD: assert property (
    latchedOff |=> latchedOff && !regulatorEnable && !switchEnable)
    else $error("latch-off released");
  AST_SYNC_RUN: assert property (
    syncSelect |-> slowTripEnable && sense.syncValid && !inFault) else $error("bad sync");
  AST_FREQ_OPEN: assert property (
    freqForceMax == sense.freqPinOpen) else $error("open frequency pin not forced");
endmodule : driver_protection_supervisor_checker
bind driver_protection_supervisor driver_protection_supervisor_checker #(
  .RESTART_CYC(RESTART_CYC)
) chk (
  .clk(clk), .rst(rst), .sense(sense), .pinCode(pinCode), .disablePinIn(disablePinIn),
  .disablePinOut(disablePinOut), .disablePinOe(disablePinOe), .sourceOn(sourceOn),
  .switchEnable(switchEnable), .regulatorEnable(regulatorEnable),
  .regHighLimit(regHighLimit), .limitLevel(limitLevel), .fastTripSixths(fastTripSixths),
  .fastTripSoftStart(fastTripSoftStart), .slowTripEnable(slowTripEnable),
  .freqForceMax(freqForceMax), .syncSelect(syncSelect), .faults(faults),
  .inFault(inFault), .latchedOff(latchedOff)
);
`default_nettype wire

// >>> testbench/tb_driver_protection_supervisor.sv
// self-checking bench for the driver protection supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_driver_protection_supervisor;
  localparam int RST_C = 50; // shortened restart delay keeps the run brief
  // band lower and upper codes, level k+1
  localparam logic [9:0] BLO [6] = '{10'h0c4, 10'h08e, 10'h063, 10'h041, 10'h025, 10'h000};
  localparam logic [9:0] BHI [6] = '{10'h12c, 10'h0c3, 10'h08d, 10'h062, 10'h040, 10'h024};
  // fault table: trigger bit, recovery bit or -1, expected flags
  localparam int TRIG [7] = '{0, 1, 14, 12, 6, 5, 3};
  localparam int REC [7] = '{-1, -1, 13, 11, -1, -1, -1};
  localparam logic [6:0] FLAG [7] = '{7'h20, 7'h40, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
  logic clk;
  logic rst;
  driver_protection_pkg::sense_s sense;
  logic [9:0] baseCode, deltaCode, pinCode;
  logic extDisable, disablePinIn, disablePinOut, disablePinOe, sourceOn, switchEnable;
  logic regulatorEnable, regHighLimit, fastTripSoftStart, slowTripEnable;
  logic freqForceMax, syncSelect, inFault, latchedOff;
  logic [2:0] limitLevel;
  logic [4:0] fastTripSixths;
  driver_protection_pkg::fault_flags_s faults;
  int seed = 25;
  int n_fail = 0;
  int num_checks = 0;
  logic [2:0] limQ [$]; // expected limit levels, oldest first
  logic [6:0] fltQ [$]; // expected fault flags, oldest first
  logic prevSw = 1'b0;
  logic prevFlt = 1'b0;
  driver_protection_supervisor #(
    .RESTART_CYC(RST_C), .SOFTSTART_CYC(40), .SLOW_TRIP_CYC(20), .SETTLE_CYC(8)
  ) dut (
    .clk(clk), .rst(rst), .sense(sense), .pinCode(pinCode), .disablePinIn(disablePinIn),
    .disablePinOut(disablePinOut), .disablePinOe(disablePinOe), .sourceOn(sourceOn),
    .switchEnable(switchEnable), .regulatorEnable(regulatorEnable),
    .regHighLimit(regHighLimit), .limitLevel(limitLevel), .fastTripSixths(fastTripSixths),
    .fastTripSoftStart(fastTripSoftStart), .slowTripEnable(slowTripEnable),
    .freqForceMax(freqForceMax), .syncSelect(syncSelect), .faults(faults),
    .inFault(inFault), .latchedOff(latchedOff)
  );
  prog_pin_model pin (
    .sourceOn(sourceOn), .disablePinOe(disablePinOe), .disablePinOut(disablePinOut),
    .baseCode(baseCode), .deltaCode(deltaCode), .extDisable(extDisable),
    .pinCode(pinCode), .disablePinIn(disablePinIn)
  );
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // print counts and verdict, then stop
  task automatic wrap_up();
    n_fail += limQ.size() + fltQ.size(); // unmatched notes count as misses
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // single bit compare
  task automatic chkBit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t bit got %h exp %h", $time, got, exp);
    end
  endtask : chkBit
  // limit level compare
  task automatic chkLvl(input logic [2:0] exp);
    num_checks++;
    if (limitLevel !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t level got %h exp %h", $time, limitLevel, exp);
    end
  endtask : chkLvl
  // fault flag compare
  task automatic chkFlg(input logic [6:0] got, input logic [6:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t flags got %h exp %h", $time, got, exp);
    end
  endtask : chkFlg
  // bounded wait for fault entry or for the run phase
  task automatic waitOut(input logic wantFault);
    int i;
    i = 0;
    while ((wantFault ? inFault : slowTripEnable) !== 1'b1 && i < 400) begin
      @(negedge clk);
      i++;
    end
    chkBit(wantFault ? inFault : slowTripEnable, 1'b1);
  endtask : waitOut
  // supply cycle, then bring-up to the run phase with a given source step
  task automatic boot(input logic [9:0] d);
    rst = 1'b1;
    sense = '0;
    sense.vccBelowRecover = 1'b1;
    sense.tempBelowRecover = 1'b1;
    deltaCode = d;
    baseCode = 10'h0c8 + 10'($random(seed) & 255);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chkBit(regHighLimit, 1'b0);
    chkBit(sourceOn, 1'b0);
    chkBit(disablePinOe, 1'b1);
    // regulator above 1 V raises its limit; a low regulator before operation must not latch
    sense.vregAbove1V = 1'b1;
    sense.vregLow = 1'b1;
    @(negedge clk);
    chkBit(regHighLimit, 1'b1);
    chkBit(latchedOff, 1'b0);
    sense.vregLow = 1'b0;
    sense.vregGood = 1'b1;
    waitOut(1'b0);
    chkBit(regHighLimit, 1'b0);
    chkBit(fastTripSoftStart, 1'b0);
  endtask : boot
  // result watcher: compares each appearing result with the oldest note
  always @(posedge clk) begin
    if (!rst && switchEnable && !prevSw && limQ.size() > 0) begin
      chkLvl(limQ.pop_front());
    end
    if (!rst && inFault && !prevFlt) begin
      chkFlg(faults, (fltQ.size() > 0) ? fltQ.pop_front() : 7'h00);
    end
    prevSw = switchEnable;
    prevFlt = inFault;
  end
  // watchdog, far beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial begin
    logic [9:0] d;
    rst = 1'b1;
    sense = '0;
    baseCode = 10'h0c8;
    deltaCode = 10'h000;
    extDisable = 1'b0;
    repeat (8) @(negedge clk);
    // each band at its lower edge, then at a random point inside
    for (int j = 0; j < 12; j++) begin
      d = BLO[j % 6];
      if (j >= 6) begin
        d = d + 10'($unsigned($random(seed)) % (BHI[j % 6] - BLO[j % 6] + 1));
      end
      limQ.push_back(3'(j % 6 + 1));
      boot(d);
    end
    // a twelve cycle overvoltage spike stays under the blanking time
    sense.vccAboveTrip = 1'b1;
    repeat (12) @(negedge clk);
    sense.vccAboveTrip = 1'b0;
    repeat (4) @(negedge clk);
    chkBit(inFault, 1'b0);
    // lost sync and open frequency pin keep running
    sense.syncValid = 1'b1;
    sense.freqPinOpen = 1'b1;
    @(negedge clk);
    chkBit(syncSelect, 1'b1);
    chkBit(freqForceMax, 1'b1);
    sense.syncValid = 1'b0;
    sense.freqPinOpen = 1'b0;
    @(negedge clk);
    chkBit(syncSelect, 1'b0);
    chkBit(slowTripEnable, 1'b1);
    // outside pull-down inhibits switching only while held
    extDisable = 1'b1;
    @(negedge clk);
    chkBit(switchEnable, 1'b0);
    extDisable = 1'b0;
    @(negedge clk);
    chkBit(switchEnable, 1'b1);
    // every fault kind, with its recovery condition held off where it has one
    for (int f = 0; f < 7; f++) begin
      if (REC[f] >= 0) sense[REC[f]] = 1'b0;
      sense[TRIG[f]] = 1'b1;
      fltQ.push_back(FLAG[f]);
      waitOut(1'b1);
      chkBit(disablePinOe, 1'b1);
      chkBit(fastTripSoftStart, 1'b1);
      sense[TRIG[f]] = 1'b0;
      if (REC[f] >= 0) begin
        repeat (RST_C + 10) @(negedge clk);
        chkBit(inFault, 1'b1);
        sense[REC[f]] = 1'b1;
      end
      waitOut(1'b0);
      chkFlg(faults, 7'h00);
    end
    // regulator overload in operation latches off until the supply cycles
    sense.vregLow = 1'b1;
    repeat (2) @(negedge clk);
    sense.vregLow = 1'b0;
    repeat (4) @(negedge clk);
    chkBit(latchedOff, 1'b1);
    chkBit(regulatorEnable, 1'b0);
    boot(10'h0c4);
    // open regulator output also latches off
    sense.vregOpen = 1'b1;
    repeat (3) @(negedge clk);
    chkBit(latchedOff, 1'b1);
    chkBit(switchEnable, 1'b0);
    wrap_up();
  end
endmodule : tb_driver_protection_supervisor
`default_nettype wire
